/* File: core/ile_ctrl.sv */
// interrupt latch/enable control with APB registers and acceptance sequencer
// assumes cpu strobes and request lines are synchronous to pclk
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module ile_ctrl
    import ile_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:2] src_req,
    input  wire logic        swi_req,
    input  wire logic        undef_req,
    input  wire logic        instr_done,
    input  wire logic        master_set_instr,
    input  wire logic        master_clear_instr,
    input  wire logic        maskable_return_instr,
    input  wire logic        nonmaskable_return_instr,
    input  wire logic        ret_imf,
    input  wire logic [15:0] cpu_pc,
    input  wire logic [15:0] cpu_sp,
    input  wire logic [6:0]  cpu_psw,
    input  wire logic [15:0] vec_rdata,
    output logic             irq_req,
    output logic             acc_busy,
    output logic             stk_wr,
    output logic      [15:0] stk_addr,
    output logic      [7:0]  stk_wdata,
    output logic             vec_rd,
    output logic      [15:0] vec_addr,
    output logic             pc_load,
    output logic      [15:0] pc_value,
    output logic             sp_load,
    output logic      [15:0] sp_value
);
    typedef struct packed {
        ile_state_t  st;
        logic [4:0]  cnt;
        logic        master_enable_flag;
        logic [23:4] ef;
        logic [4:0]  sel;
        logic        sav_imf;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [6:0]  program_status_word;
        logic        stk_wr;
        logic [15:0] stk_addr;
        logic [7:0]  stk_wdata;
        logic        vec_rd;
        logic [15:0] vec_addr;
        logic        pc_load;
        logic        sp_load;
        logic [31:0] prdata;
        logic        pslverr;
    } ile_ctrl_t;

    ile_ctrl_t r;
    ile_ctrl_t next_r;

    logic [23:2] latch;
    logic [23:2] sw_clr;
    logic [23:2] acc_clr;
    logic [23:0] cand;
    logic [23:0] lat24;
    logic [23:0] ef24;
    logic [23:0] wz;
    logic        found;
    logic [4:0]  pick;
    logic        accept;
    logic        setup;
    logic        wr;

    function automatic logic is_reg(input logic [9:0] a);
        return a[1:0] == 2'b00 && (a[9:2] == IDX_EN_EXT || a[9:2] == IDX_PEND_EXT ||
               a[9:2] == IDX_EN_LOW || a[9:2] == IDX_EN_HIGH ||
               a[9:2] == IDX_PEND_LOW || a[9:2] == IDX_PEND_HIGH);
    endfunction

    assign lat24 = {latch, 2'b00};
    assign ef24  = {r.ef, 4'h0};
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite && is_reg(paddr);

    // non-maskables bypass every enable; maskables need the master flag too
    assign cand[1:0]  = {swi_req, undef_req};
    assign cand[3:2]  = latch[3:2];
    assign cand[23:4] = latch[23:4] & r.ef & {20{r.master_enable_flag}};
    assign irq_req    = |cand;

    ile_prio_pick u_pick (
        .pclk  (pclk),
        .cand  (cand),
        .found (found),
        .pick  (pick)
    );

    // taken only at the instruction's final cycle
    assign accept = (r.st == ILE_IDLE) && instr_done && found;

    always_comb begin
        acc_clr = '0;
        if (accept && pick >= SRC_FIRST_IL)
            acc_clr[pick] = 1'b1;
    end

    // zero bits written to a latch byte clear; ones do nothing
    always_comb begin
        wz = '0;
        if (wr) begin
            case (paddr[9:2])
                IDX_PEND_LOW:  wz[7:0]   = ~pwdata[7:0];
                IDX_PEND_HIGH: wz[15:8]  = ~pwdata[7:0];
                IDX_PEND_EXT:  wz[23:16] = ~pwdata[7:0];
                default:       wz        = '0;
            endcase
        end
    end
    assign sw_clr = wz[23:2];

    ile_latch_bank u_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .req_set (src_req),
        .sw_clr  (sw_clr),
        .acc_clr (acc_clr),
        .latch   (latch)
    );

    always_comb begin
        next_r         = r;
        next_r.stk_wr  = 1'b0;
        next_r.vec_rd  = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.sp_load = 1'b0;

        // read data captured in the setup cycle, so access needs no wait
        if (setup) begin
            next_r.pslverr = !is_reg(paddr);
            case (paddr[9:2])
                IDX_PEND_LOW:  next_r.prdata = {24'h000000, lat24[7:0]};
                IDX_PEND_HIGH: next_r.prdata = {24'h000000, lat24[15:8]};
                IDX_PEND_EXT:  next_r.prdata = {24'h000000, lat24[23:16]};
                IDX_EN_LOW:    next_r.prdata = {24'h000000, ef24[7:1], r.master_enable_flag};
                IDX_EN_HIGH:   next_r.prdata = {24'h000000, ef24[15:8]};
                IDX_EN_EXT:    next_r.prdata = {24'h000000, ef24[23:16]};
                default:       next_r.prdata = 32'h00000000;
            endcase
        end

        if (wr) begin
            case (paddr[9:2])
                IDX_EN_LOW: begin
                    next_r.ef[7:4] = pwdata[7:4];
                    next_r.master_enable_flag     = pwdata[IMF_BIT];
                end
                IDX_EN_HIGH: next_r.ef[15:8]  = pwdata[7:0];
                IDX_EN_EXT:  next_r.ef[23:16] = pwdata[7:0];
                default:     next_r.ef        = r.ef;
            endcase
        end

        // later sources of change override earlier ones
        if (master_set_instr)
            next_r.master_enable_flag = 1'b1;
        if (master_clear_instr)
            next_r.master_enable_flag = 1'b0;
        if (maskable_return_instr || nonmaskable_return_instr)
            next_r.master_enable_flag = ret_imf;

        case (r.st)
            ILE_IDLE: begin
                next_r.cnt = 5'h00;
                if (accept) begin
                    next_r.st      = ILE_STACK;
                    next_r.sel     = pick;
                    next_r.sav_imf = r.master_enable_flag;
                    next_r.master_enable_flag     = 1'b0;
                    next_r.sp      = cpu_sp;
                    next_r.pc      = cpu_pc;
                    next_r.program_status_word     = cpu_psw;
                end
            end
            ILE_STACK: begin
                next_r.cnt = r.cnt + 5'h01;
                if (r.cnt == CNT_PUSH_PSW) begin
                    next_r.stk_wr    = 1'b1;
                    next_r.stk_addr  = r.sp;
                    next_r.stk_wdata = {r.program_status_word, r.sav_imf};
                end
                if (r.cnt == CNT_PUSH_PCH) begin
                    next_r.stk_wr    = 1'b1;
                    next_r.stk_addr  = r.sp - 16'h0001;
                    next_r.stk_wdata = r.pc[15:8];
                end
                if (r.cnt == CNT_PUSH_PCL) begin
                    next_r.stk_wr    = 1'b1;
                    next_r.stk_addr  = r.sp - 16'h0002;
                    next_r.stk_wdata = r.pc[7:0];
                end
                if (r.cnt == CNT_VEC_RD) begin
                    next_r.st       = ILE_VECTOR;
                    next_r.vec_rd   = 1'b1;
                    next_r.vec_addr = ile_vector_of(r.sel);
                end
            end
            ILE_VECTOR: begin
                next_r.cnt = r.cnt + 5'h01;
                if (r.cnt == CNT_VEC_TAKE)
                    next_r.pc = vec_rdata;
                if (r.cnt == CNT_LOAD) begin
                    next_r.pc_load = 1'b1;
                    next_r.sp_load = 1'b1;
                    next_r.sp      = r.sp - SP_PUSHES;
                end
                if (r.cnt == CNT_LAST)
                    next_r.st = ILE_IDLE;
            end
            default: next_r.st = ILE_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r     <= '0;
            r.st  <= ILE_IDLE;
            r.master_enable_flag <= RST_IMF;
            r.ef  <= RST_EF;
        end else begin
            r <= next_r;
        end
    end

    assign prdata    = r.prdata;
    assign pready    = 1'b1;
    assign pslverr   = r.pslverr && psel && penable;
    assign acc_busy  = r.st != ILE_IDLE;
    assign stk_wr    = r.stk_wr;
    assign stk_addr  = r.stk_addr;
    assign stk_wdata = r.stk_wdata;
    assign vec_rd    = r.vec_rd;
    assign vec_addr  = r.vec_addr;
    assign pc_load   = r.pc_load;
    assign pc_value  = r.pc;
    assign sp_load   = r.sp_load;
    assign sp_value  = r.sp;

    property p_imf_saved_cleared;
        @(posedge pclk) disable iff (!presetn)
        accept |=> (!r.master_enable_flag && r.sav_imf == $past(r.master_enable_flag));
    endproperty
    a_imf_saved_cleared: assert property (p_imf_saved_cleared)
        else $error("master flag not saved and cleared at acceptance");

    property p_masked_blocked;
        @(posedge pclk) disable iff (!presetn)
        (!r.master_enable_flag && cand[3:0] == 4'h0) |-> !accept;
    endproperty
    a_masked_blocked: assert property (p_masked_blocked)
        else $error("maskable source accepted with master flag clear");

    property p_seq_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(acc_busy) |-> ##31 (pc_load && sp_load) ##1 !acc_busy;
    endproperty
    a_seq_len: assert property (p_seq_len)
        else $error("acceptance not eight machine cycles");

    property p_push_order;
        @(posedge pclk) disable iff (!presetn)
        $rose(acc_busy) |-> ##8 (stk_wr && stk_addr == r.sp) ##4
            (stk_wr && stk_addr == r.sp - 16'h0001) ##4
            (stk_wr && stk_addr == r.sp - 16'h0002 && stk_wdata == r.pc[7:0]);
    endproperty
    a_push_order: assert property (p_push_order)
        else $error("stack pushes out of order");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        vec_rd |-> (vec_addr == ile_vector_of(r.sel)) ##11 (pc_load && pc_value == $past(vec_rdata, 10));
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector address or loaded pc wrong");

    property p_latch_taken;
        @(posedge pclk) disable iff (!presetn)
        (accept && pick >= SRC_FIRST_IL && !src_req[pick]) |=> !lat24[$past(pick)];
    endproperty
    a_latch_taken: assert property (p_latch_taken)
        else $error("accepted latch not cleared");

    property p_accept_start;
        @(posedge pclk) disable iff (!presetn)
        (!acc_busy && instr_done && irq_req) |=> acc_busy;
    endproperty
    a_accept_start: assert property (p_accept_start)
        else $error("pending request not taken at instruction end");

    property p_nm_ungated;
        @(posedge pclk) disable iff (!presetn)
        (latch[3:2] != 2'b00) |-> irq_req;
    endproperty
    a_nm_ungated: assert property (p_nm_ungated)
        else $error("non-maskable latch does not request service");

    property p_return_imf;
        @(posedge pclk) disable iff (!presetn)
        ((maskable_return_instr || nonmaskable_return_instr) && !accept)
            |=> (r.master_enable_flag == $past(ret_imf));
    endproperty
    a_return_imf: assert property (p_return_imf)
        else $error("return did not reload the master flag");

    property p_sp_moved;
        @(posedge pclk) disable iff (!presetn)
        $rose(acc_busy) |-> ##31 (sp_value == $past(cpu_sp, 32) - SP_PUSHES);
    endproperty
    a_sp_moved: assert property (p_sp_moved)
        else $error("stack pointer not lowered by three");
endmodule

/* File: core/ile_pkg.sv */
// constants, register map and state type of the interrupt latch/enable sequencer
// assumes a 10 MHz pclk and an APB master with 32-bit data
package ile_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EN_EXT    = 8'h2C;
    localparam logic [7:0] IDX_PEND_EXT  = 8'h2E;
    localparam logic [7:0] IDX_EN_LOW    = 8'h3A;
    localparam logic [7:0] IDX_EN_HIGH   = 8'h3B;
    localparam logic [7:0] IDX_PEND_LOW  = 8'h3C;
    localparam logic [7:0] IDX_PEND_HIGH = 8'h3D;
    localparam int         IMF_BIT       = 0;
    // source numbers; 0 and 1 have no latch
    localparam logic [4:0] SRC_UNDEF     = 5'h00;
    localparam logic [4:0] SRC_SWI       = 5'h01;
    localparam logic [4:0] SRC_FIRST_IL  = 5'h02;
    localparam logic [4:0] SRC_FIRST_EF  = 5'h04;
    localparam logic [4:0] SRC_BANK2     = 5'h10;
    localparam logic [15:0] VEC_TOP      = 16'hFFFE;
    localparam logic [15:0] VEC_BANK2    = 16'hFFDE;
    // reset values
    localparam logic        RST_IMF      = 1'b0;
    localparam logic [19:0] RST_EF       = 20'h00000;
    localparam logic [21:0] RST_LATCH    = 22'h000000;
    // acceptance timing in clocks
    localparam int          MC_CLKS      = 4;
    localparam int          ACC_MC       = 8;
    localparam int          ACC_CLKS     = MC_CLKS * ACC_MC;
    localparam int          LAT_MAX_CLKS = 38;
    localparam logic [4:0]  CNT_PUSH_PSW = 5'(2 * MC_CLKS - 1);
    localparam logic [4:0]  CNT_PUSH_PCH = 5'(3 * MC_CLKS - 1);
    localparam logic [4:0]  CNT_PUSH_PCL = 5'(4 * MC_CLKS - 1);
    localparam logic [4:0]  CNT_VEC_RD   = 5'(5 * MC_CLKS - 1);
    localparam logic [4:0]  CNT_VEC_TAKE = 5'(5 * MC_CLKS + 1);
    localparam logic [4:0]  CNT_LOAD     = 5'(ACC_CLKS - 2);
    localparam logic [4:0]  CNT_LAST     = 5'(ACC_CLKS - 1);
    localparam logic [15:0] SP_PUSHES    = 16'h0003;

    typedef enum logic [1:0] {
        ILE_IDLE   = 2'b00,
        ILE_STACK  = 2'b01,
        ILE_VECTOR = 2'b10
    } ile_state_t;

    function automatic logic [15:0] ile_vector_of(input logic [4:0] n);
        logic [15:0] off;
        off = {10'h000, n, 1'b0};
        // both unlatched sources share one slot
        if (n == SRC_SWI || n == SRC_UNDEF)
            return VEC_TOP - 16'h0002;
        else if (n >= SRC_BANK2)
            return VEC_BANK2 - off;
        else
            return VEC_TOP - off;
    endfunction
endpackage

/* File: core/ile_latch_bank.sv */
// pending latches for request lines 2 to 23
// assumes requests and clears come from logic on pclk
`timescale 1ns/1ps
module ile_latch_bank
    import ile_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [23:2] req_set,
    input  wire logic [23:2] sw_clr,
    input  wire logic [23:2] acc_clr,
    output logic      [23:2] latch
);
    typedef struct packed {
        logic [23:2] lat;
    } ile_bank_t;

    ile_bank_t r;
    ile_bank_t next_r;

    always_comb begin
        next_r = r;
        // a request in the same cycle as any clear keeps the latch set
        next_r.lat = (r.lat & ~sw_clr & ~acc_clr) | req_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            r <= '{lat: RST_LATCH};
        else
            r <= next_r;
    end

    assign latch = r.lat;

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (req_set != '0) |=> ((latch & $past(req_set)) == $past(req_set));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("requested latch not set");

    property p_no_sw_set;
        @(posedge pclk) disable iff (!presetn)
        ##1 ((latch & ~$past(latch) & ~$past(req_set)) == '0);
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("latch set without a request");
endmodule

/* File: core/ile_prio_pick.sv */
// fixed priority pick: lowest source number wins
// assumes candidates are already gated by the enables
`timescale 1ns/1ps
module ile_prio_pick
    import ile_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic [23:0] cand,
    output logic             found,
    output logic      [4:0]  pick
);
    always_comb begin
        found = 1'b0;
        pick  = 5'h00;
        for (int i = 23; i >= 0; i--) begin
            if (cand[i]) begin
                found = 1'b1;
                pick  = 5'(i);
            end
        end
    end

    property p_pick_valid;
        @(posedge pclk) found |-> cand[pick];
    endproperty
    a_pick_valid: assert property (p_pick_valid)
        else $error("picked source not a candidate");
endmodule

/* File: tb/ile_cpu_model.sv */
// cpu core model: ends instructions, supplies pc/sp/psw and vector words
// assumes pulses and data from ile_ctrl on pclk; slow selects 9-cycle-machine instructions
`timescale 1ns/1ps
module ile_cpu_model
    import ile_pkg::*;
#(
    parameter logic [15:0] PC_VAL  = 16'h1234,
    parameter logic [15:0] SP_VAL  = 16'h0200,
    parameter logic [6:0]  PSW_VAL = 7'h55
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        acc_busy,
    input  wire logic        vec_rd,
    input  wire logic [15:0] vec_addr,
    output logic             instr_done,
    output logic      [15:0] cpu_pc,
    output logic      [15:0] cpu_sp,
    output logic      [6:0]  cpu_psw,
    output logic      [15:0] vec_rdata
);
    logic [5:0]  cyc;
    logic [1:0]  hold;
    logic [15:0] word;

    assign cpu_pc = PC_VAL;
    assign cpu_sp = SP_VAL;
    assign cpu_psw = PSW_VAL;
    // no instruction runs while the acceptance sequence owns the bus
    assign instr_done = presetn && !acc_busy && (cyc == 6'h00);
    // outside its hold time the table word is garbage that moves with cyc, which acceptance holds at 1
    assign vec_rdata = (hold != 2'h0) ? word : (~word ^ {cyc, cyc, cyc[3:0]});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= 6'h00;
            hold <= 2'h0;
            word <= 16'h0000;
        end else begin
            if (acc_busy)
                cyc <= 6'h01;
            else if (cyc == 6'h00)
                cyc <= slow ? 6'h23 : 6'h03;
            else
                cyc <= cyc - 6'h01;
            if (vec_rd) begin
                hold <= 2'h3;
                word <= vec_addr ^ 16'h5A5A;
            end else if (hold != 2'h0) begin
                hold <= hold - 2'h1;
            end
        end
    end
endmodule

/* File: tb/irq_latch_enable_sequencer_bench.sv */
// self-checking bench for ile_ctrl: apb register tasks plus acceptance monitor
// assumes ile_cpu_model stands in for the cpu core; bench drives requests and cpu strobes
`timescale 1ns/1ps
module irq_latch_enable_sequencer_bench
    import ile_pkg::*;
;
    localparam logic [15:0] PC_V = 16'h1234;
    localparam logic [15:0] SP_V = 16'h0200;
    localparam logic [6:0]  PSW_V = 7'h55;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [23:2] src_req;
    logic        swi_req, undef_req, instr_done, master_set_instr, master_clear_instr;
    logic        maskable_return_instr, nonmaskable_return_instr, ret_imf, slow;
    logic [15:0] cpu_pc, cpu_sp, vec_rdata, stk_addr, vec_addr, pc_value, sp_value;
    logic [6:0]  cpu_psw;
    logic [7:0]  stk_wdata;
    logic        irq_req, acc_busy, stk_wr, vec_rd, pc_load, sp_load;
    int          n_mismatch, num_checks, tmo, busy_len, last_len, n_acc, acc_start, t0, n0;
    logic [15:0] q_addr[$];
    logic [7:0]  q_data[$];
    logic [15:0] seen_vec, seen_pc, seen_sp;
    logic [31:0] r;
    logic        e;

    ile_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req(src_req), .swi_req(swi_req), .undef_req(undef_req),
        .instr_done(instr_done), .master_set_instr(master_set_instr),
        .master_clear_instr(master_clear_instr), .maskable_return_instr(maskable_return_instr),
        .nonmaskable_return_instr(nonmaskable_return_instr), .ret_imf(ret_imf),
        .cpu_pc(cpu_pc), .cpu_sp(cpu_sp), .cpu_psw(cpu_psw), .vec_rdata(vec_rdata),
        .irq_req(irq_req), .acc_busy(acc_busy), .stk_wr(stk_wr), .stk_addr(stk_addr),
        .stk_wdata(stk_wdata), .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load),
        .pc_value(pc_value), .sp_load(sp_load), .sp_value(sp_value));
    ile_cpu_model #(.PC_VAL(PC_V), .SP_VAL(SP_V), .PSW_VAL(PSW_V)) cpu (.pclk(pclk),
        .presetn(presetn), .slow(slow), .acc_busy(acc_busy), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .instr_done(instr_done), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp),
        .cpu_psw(cpu_psw), .vec_rdata(vec_rdata));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // acceptance monitor; sees the values of the cycle just ended
    always @(posedge pclk) begin
        tmo++;
        if (stk_wr === 1'b1) begin
            q_addr.push_back(stk_addr);
            q_data.push_back(stk_wdata);
        end
        if (vec_rd === 1'b1) seen_vec = vec_addr;
        if (pc_load === 1'b1) seen_pc = pc_value;
        if (sp_load === 1'b1) seen_sp = sp_value;
        if (acc_busy === 1'b1) begin
            if (busy_len == 0) acc_start = tmo;
            busy_len++;
        end else if (busy_len != 0) begin
            last_len = busy_len;
            busy_len = 0;
            n_acc++;
        end
        if (tmo == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; req is raised for the access cycle only
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [23:2] req, output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        src_req <= req;
        @(posedge pclk);
        // pready high ends this wait; the bench timeout ends it otherwise
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        src_req <= '0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, idx, d, '0, x, y);
    endtask

    task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] x;
        logic        y;
        apb(1'b0, idx, 8'h00, '0, x, y);
        chk(what, {24'h000000, exp}, x);
        chk(what, 32'h0, {31'h0, y});
    endtask

    function automatic logic [23:2] one(input int n);
        one = '0;
        one[n] = 1'b1;
    endfunction

    task automatic pulse_req(input logic [23:2] m);
        src_req <= m;
        @(posedge pclk);
        src_req <= '0;
        @(posedge pclk);
    endtask

    task automatic cpu_op(input logic s, input logic c, input logic rm, input logic ri);
        master_set_instr <= s;
        master_clear_instr <= c;
        maskable_return_instr <= rm;
        nonmaskable_return_instr <= !s && !c && !rm;
        ret_imf <= ri;
        @(posedge pclk);
        {master_set_instr, master_clear_instr} <= 2'b00;
        {maskable_return_instr, nonmaskable_return_instr, ret_imf} <= 3'b000;
    endtask

    task automatic mark();
        t0 = tmo;
        n0 = n_acc;
        q_addr.delete();
        q_data.delete();
    endtask

    task automatic accept(input string what, input logic [15:0] v, input logic master_enable_flag);
        while (n_acc == n0 && tmo - t0 < 300) begin
            @(posedge pclk);
            // unlatched sources must fall once taken or they are taken again
            if (acc_busy === 1'b1)
                {swi_req, undef_req} <= 2'b00;
        end
        chk(what, n0 + 1, n_acc);
        chk(what, 32'h1, {31'h0, (acc_start - t0) <= LAT_MAX_CLKS + 2});
        chk(what, ACC_CLKS, last_len);
        chk(what, 32'd3, q_addr.size());
        for (int i = 0; i < 3; i++) chk(what, SP_V - 16'(i), q_addr[i]);
        chk(what, {24'h0, PSW_V, master_enable_flag}, q_data[0]);
        chk(what, {24'h0, PC_V[15:8]}, q_data[1]);
        chk(what, {24'h0, PC_V[7:0]}, q_data[2]);
        chk(what, v, seen_vec);
        chk(what, v ^ 16'h5A5A, seen_pc);
        chk(what, SP_V - SP_PUSHES, seen_sp);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, swi_req, undef_req, slow} = '0;
        {master_set_instr, master_clear_instr, maskable_return_instr} = '0;
        {nonmaskable_return_instr, ret_imf} = '0;
        {paddr, pwdata, src_req} = '0;
        {n_mismatch, num_checks, tmo, busy_len, last_len, n_acc, acc_start} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("pend low", IDX_PEND_LOW, 8'h00);
        rd("pend high", IDX_PEND_HIGH, 8'h00);
        rd("pend ext", IDX_PEND_EXT, 8'h00);
        rd("en low", IDX_EN_LOW, 8'h00);
        rd("en high", IDX_EN_HIGH, 8'h00);
        rd("en ext", IDX_EN_EXT, 8'h00);
        apb(1'b0, 8'hFF, 8'h00, '0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr(IDX_PEND_LOW, 8'hFF);
        rd("pend set by sw", IDX_PEND_LOW, 8'h00);
        pulse_req(one(8) | one(9));
        chk("irq disabled", 32'h0, {31'h0, irq_req});
        repeat (10) @(posedge pclk);
        rd("pend held", IDX_PEND_HIGH, 8'h03);
        wr(IDX_PEND_HIGH, 8'hFD);
        rd("clear one", IDX_PEND_HIGH, 8'h01);
        wr(IDX_PEND_HIGH, 8'hFE);
        rd("clear two", IDX_PEND_HIGH, 8'h00);
        apb(1'b1, IDX_PEND_HIGH, 8'h00, one(12), r, e);
        rd("req beats clear", IDX_PEND_HIGH, 8'h10);
        wr(IDX_PEND_HIGH, 8'hEF);
        rd("pend high clr", IDX_PEND_HIGH, 8'h00);
        wr(IDX_EN_HIGH, 8'hA5);
        rd("en high rw", IDX_EN_HIGH, 8'hA5);
        wr(IDX_EN_HIGH, 8'h00);
        wr(IDX_EN_LOW, 8'hF0);
        rd("en low rw", IDX_EN_LOW, 8'hF0);
        wr(IDX_EN_LOW, 8'h01);
        rd("imf rw", IDX_EN_LOW, 8'h01);
        wr(IDX_EN_LOW, 8'h00);
        cpu_op(1'b1, 1'b0, 1'b0, 1'b1);
        rd("imf set", IDX_EN_LOW, 8'h01);
        cpu_op(1'b0, 1'b1, 1'b0, 1'b1);
        rd("imf clr", IDX_EN_LOW, 8'h00);
        wr(IDX_EN_LOW, 8'h20);
        wr(IDX_EN_EXT, 8'h10);
        pulse_req(one(5) | one(20));
        chk("imf blocks", 32'h0, {31'h0, irq_req});
        mark();
        cpu_op(1'b1, 1'b0, 1'b0, 1'b1);
        accept("src5", 16'hFFF4, 1'b1);
        rd("latch taken", IDX_PEND_LOW, 8'h00);
        rd("latch kept", IDX_PEND_EXT, 8'h10);
        rd("imf cleared", IDX_EN_LOW, 8'h20);
        chk("imf blocks nest", 32'h0, {31'h0, irq_req});
        slow <= 1'b1;
        mark();
        cpu_op(1'b0, 1'b0, 1'b1, 1'b1);
        accept("src20", 16'hFFB6, 1'b1);
        rd("ext taken", IDX_PEND_EXT, 8'h00);
        cpu_op(1'b0, 1'b0, 1'b0, 1'b1);
        rd("imf restored", IDX_EN_LOW, 8'h21);
        slow <= 1'b0;
        mark();
        pulse_req(one(3));
        accept("watchdog", 16'hFFF8, 1'b1);
        mark();
        pulse_req(one(2));
        accept("trap", 16'hFFFA, 1'b0);
        mark();
        swi_req <= 1'b1;
        accept("swi", 16'hFFFC, 1'b0);
        mark();
        undef_req <= 1'b1;
        accept("undef", 16'hFFFC, 1'b0);
        pulse_req(one(6) | one(7));
        wr(IDX_PEND_LOW, 8'h4C);
        rd("pend low clr", IDX_PEND_LOW, 8'h40);
        print_verdict();
    end
endmodule
